// ==== core/scml_loader.sv ====
// Serial configuration loader: mode decode, clock generation, bit capture, chain pass-through
//
// Notes on behaviour
// RULE1 - Mode codes 000 and 100 select self-clocked serial; device drives config clock.
// RULE2 - Mode codes 111 and 011 select slave serial; config clock is input.
// RULE3 - Mode pins pulled weakly high; open pins give slave serial.
// RULE4 - Test-port loading always allowed; test mode only disables other modes.
// RULE5 - Top mode bit chooses user I/O pull-ups or floating before configuration.
// RULE6 - Config clock direction follows mode: output when self-clocked, else input.
// RULE7 - Upstream source sets data up before the rising clock edge it supplies.
// RULE8 - Self-clocked mode samples one data bit on each generated rising edge.
// RULE9 - After own load, further incoming bits are forwarded to chain output.
// RULE10 - Chain output changes on rising config clock edge.
// RULE11 - Oscillator starts slow; loaded bits may raise rate, never lower it.
// RULE12 - Generated clock runs at 2.5 MHz until rate bits loaded.
// RULE13 - Rate setting never selects above 60 MHz.
// RULE14 - No rate specified in design means 4 MHz.
// RULE15 - Source waits for every memory-clear status output high before sending.
// RULE16 - Controller holds restart pin high before reconfiguration proceeds.
// RULE17 - After completion unused I/O are disabled three-state with weak pull-down.
// RULE18 - PROM reset follows memory-clear status; PROM enable follows done.
// RULE19 - Memory-clear status rises after clearing; done rises when load completes.
// RULE20 - Mode pins sampled at configuration start and held until restart.
`timescale 1ns/1ps
`include "scml_regs.svh"
module scml_loader
   import scml_pkg::*;
#(
   parameter int LOAD_BITS = 64,
   parameter int RATE_POS  = 8,
   parameter int CLEAR_CYC = 256
) (
   input  wire logic                  CLK,
   input  wire logic                  RSTN,
   input  wire logic                  PROGRAM_N,
   input  wire logic                  MODE_SELECT_BIT2,
   input  wire logic                  MODE_SELECT_BIT1,
   input  wire logic                  MODE_SELECT_BIT0,
   output logic                       MODE_PULLUP_EN,
   input  wire logic                  CONFIG_CLOCK_I,
   output logic                       CONFIG_CLOCK_O,
   output logic                       CONFIG_CLOCK_OE,
   input  wire logic                  DIN,
   output logic                       DOUT,
   output logic                       INIT_DONE,
   output logic                       CONFIG_DONE,
   output logic                       SCAN_MODE,
   output logic                       IO_PULLUP_EN,
   output logic                       IO_PULLDOWN_EN,
   output logic [`SCML_RATE_BITS-1:0] CLOCK_RATE_SETTING,
   output logic                       CFG_DATA,
   output logic                       CFG_VALID,
   input  wire logic                  CFG_READY
);
   logic [2:0]  mode_s1_r, mode_s2_r;
   logic        c1_r, c2_r, c3_r;
   logic        d1_r, d2_r;
   logic        p1_r, p2_r;
   scml_mode_t  mode_r;
   scml_state_t st_r;
   logic [15:0] cnt_r;
   logic [7:0]  half_r;
   logic [7:0]  div_r;
   logic        gclk_r;
   logic        gen_rise;
   logic        ext_rise;
   logic        bit_stb;
   logic [3:0]  rate_sh_r;
   logic        f_ready;
   logic        f_valid;
   logic        f_data;
   logic        push;
   logic [7:0]  new_half;

   // Rate code to half period; 0 means unspecified
   function automatic logic [7:0] rate_half(input logic [3:0] code);
      case (code)
         4'h0:    rate_half = `SCML_HALF_DFLT; // RULE14
         4'h1:    rate_half = 8'(`SCML_HALF(5000));
         4'h2:    rate_half = 8'(`SCML_HALF(10000));
         4'h3:    rate_half = 8'(`SCML_HALF(20000));
         4'h4:    rate_half = 8'(`SCML_HALF(40000));
         default: rate_half = `SCML_HALF_MIN; // RULE13
      endcase
   endfunction

   // Pin synchronisers
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         mode_s1_r <= 3'h7;
         mode_s2_r <= 3'h7;
         c1_r <= 1'b0;
         c2_r <= 1'b0;
         c3_r <= 1'b0;
         d1_r <= 1'b0;
         d2_r <= 1'b0;
         p1_r <= 1'b0;
         p2_r <= 1'b0;
      end else begin
         mode_s1_r <= {MODE_SELECT_BIT2, MODE_SELECT_BIT1, MODE_SELECT_BIT0};
         mode_s2_r <= mode_s1_r;
         c1_r <= CONFIG_CLOCK_I;
         c2_r <= c1_r;
         c3_r <= c2_r;
         d1_r <= DIN;
         d2_r <= d1_r;
         p1_r <= PROGRAM_N;
         p2_r <= p1_r;
      end
   end

   assign ext_rise = c2_r && !c3_r;

   // Mode capture at start of configuration
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         mode_r         <= SCML_MODE_SLAVE; // RULE3
         MODE_PULLUP_EN <= 1'b1; // RULE3
         IO_PULLUP_EN   <= 1'b0;
      end else if (st_r == SCML_ST_CLEAR && cnt_r == 16'h0000) begin // RULE20
         case (mode_s2_r)
            `SCML_CODE_MS0, `SCML_CODE_MS1: mode_r <= SCML_MODE_MASTER; // RULE1
            `SCML_CODE_SS0, `SCML_CODE_SS1: mode_r <= SCML_MODE_SLAVE; // RULE2
            `SCML_CODE_BS0, `SCML_CODE_BS1: mode_r <= SCML_MODE_SCAN; // RULE4
            default:                        mode_r <= SCML_MODE_PARALLEL;
         endcase
         IO_PULLUP_EN <= !mode_s2_r[2]; // RULE5
      end else if (CONFIG_DONE) begin
         IO_PULLUP_EN <= 1'b0; // RULE17
      end
   end

   // Clock generator
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         div_r           <= 8'h00;
         gclk_r          <= 1'b0;
         CONFIG_CLOCK_O  <= 1'b0;
         CONFIG_CLOCK_OE <= 1'b0;
      end else begin
         // Drive starts together with the clear-done flag and stops with a restart
         CONFIG_CLOCK_OE <= (mode_r == SCML_MODE_MASTER) && p2_r // RULE6
                            && (st_r != SCML_ST_CLEAR || cnt_r == 16'(CLEAR_CYC));
         if (mode_r != SCML_MODE_MASTER || st_r == SCML_ST_CLEAR || st_r == SCML_ST_IDLE) begin
            div_r  <= 8'h00;
            gclk_r <= 1'b0;
         end else if (div_r + 8'h01 >= half_r) begin
            div_r  <= 8'h00;
            gclk_r <= !gclk_r;
         end else begin
            div_r <= div_r + 8'h01;
         end
         CONFIG_CLOCK_O <= gclk_r;
      end
   end

   assign gen_rise = (div_r + 8'h01 >= half_r) && !gclk_r && (mode_r == SCML_MODE_MASTER)
                     && (st_r == SCML_ST_LOAD || st_r == SCML_ST_PASS);
   assign bit_stb  = (mode_r == SCML_MODE_MASTER) ? gen_rise // RULE8
                     : (mode_r == SCML_MODE_SLAVE) && ext_rise; // RULE7
   assign new_half = rate_half({d2_r, rate_sh_r[3:1]});

   // Main sequence
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         st_r        <= SCML_ST_CLEAR;
         cnt_r       <= 16'h0000;
         half_r      <= `SCML_HALF_INIT;
         rate_sh_r   <= `SCML_RATE_DFLT_CODE;
         INIT_DONE   <= 1'b0;
         CONFIG_DONE <= 1'b0;
         SCAN_MODE   <= 1'b0;
         CLOCK_RATE_SETTING <= `SCML_RATE_DFLT_CODE;
      end else if (!p2_r) begin
         st_r        <= SCML_ST_CLEAR; // RULE16
         cnt_r       <= 16'h0000;
         half_r      <= `SCML_HALF_INIT; // RULE12
         INIT_DONE   <= 1'b0;
         CONFIG_DONE <= 1'b0;
      end else begin
         SCAN_MODE <= (mode_r == SCML_MODE_SCAN);
         case (st_r)
            SCML_ST_CLEAR: begin
               if (cnt_r == 16'(CLEAR_CYC)) begin
                  st_r      <= SCML_ST_WAIT;
                  cnt_r     <= 16'h0000;
                  INIT_DONE <= 1'b1; // RULE19 RULE18
               end else begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end
            SCML_ST_WAIT: begin
               // RULE15
               if (mode_r == SCML_MODE_MASTER || mode_r == SCML_MODE_SLAVE) begin
                  st_r <= SCML_ST_LOAD;
               end
            end
            SCML_ST_LOAD: begin
               if (push) begin
                  cnt_r <= cnt_r + 16'h0001;
                  if (cnt_r < 16'(RATE_POS + `SCML_RATE_BITS)
                      && cnt_r >= 16'(RATE_POS)) begin
                     rate_sh_r <= {d2_r, rate_sh_r[3:1]};
                  end
                  if (cnt_r == 16'(RATE_POS + `SCML_RATE_BITS - 1)) begin
                     CLOCK_RATE_SETTING <= {d2_r, rate_sh_r[3:1]};
                     if (new_half < half_r) begin
                        half_r <= new_half; // RULE11 RULE12 RULE13
                     end
                  end
                  if (cnt_r == 16'(LOAD_BITS - 1)) begin
                     st_r <= SCML_ST_PASS;
                  end
               end
            end
            SCML_ST_PASS: begin
               if (!f_valid) begin
                  CONFIG_DONE <= 1'b1; // RULE19 RULE18
               end
            end
            default: st_r <= SCML_ST_IDLE;
         endcase
      end
   end

   assign push = bit_stb && st_r == SCML_ST_LOAD;

   // Bits beyond own load go down the chain
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         DOUT <= 1'b0;
      end else if (bit_stb && st_r == SCML_ST_PASS) begin
         DOUT <= d2_r; // RULE9 RULE10
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         IO_PULLDOWN_EN <= 1'b0;
      end else begin
         IO_PULLDOWN_EN <= CONFIG_DONE; // RULE17
      end
   end

   scml_fifo #(
      .WIDTH (1),
      .DEPTH (`SCML_FIFO_DEPTH),
      .AW    (`SCML_FIFO_AW)
   ) u_fifo (
      .clk       (CLK),
      .rst_n     (RSTN),
      .clr       (!p2_r),
      .in_data   (d2_r),
      .in_valid  (push),
      .in_ready  (f_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (CFG_READY && CFG_VALID)
   );

   // Output stage of configuration stream
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         CFG_DATA  <= 1'b0;
         CFG_VALID <= 1'b0;
      end else if (!CFG_VALID || CFG_READY) begin
         CFG_DATA  <= f_data;
         CFG_VALID <= f_valid && !(CFG_VALID && CFG_READY);
      end
   end
endmodule

// ==== core/scml_regs.svh ====
// Constants for the serial configuration mode loader
`ifndef SCML_REGS_SVH
`define SCML_REGS_SVH
`define SCML_CLK_MHZ        250
`define SCML_RATE_INIT_KHZ  2500
`define SCML_RATE_DFLT_KHZ  4000
`define SCML_RATE_MAX_KHZ   60000
// Half period in system clocks: ceil(f_clk / (2 * f_cfg))
`define SCML_HALF(khz)      ((`SCML_CLK_MHZ * 1000 + 2 * (khz) - 1) / (2 * (khz)))
`define SCML_HALF_INIT      8'd50
`define SCML_HALF_DFLT      8'd32
`define SCML_HALF_MIN       8'd3
`define SCML_CODE_MS0       3'h0
`define SCML_CODE_MS1       3'h4
`define SCML_CODE_SS0       3'h7
`define SCML_CODE_SS1       3'h3
`define SCML_CODE_BS0       3'h5
`define SCML_CODE_BS1       3'h1
`define SCML_RATE_DFLT_CODE 4'h0
`define SCML_RATE_BITS      4
`define SCML_FIFO_DEPTH     32
`define SCML_FIFO_AW        5
`endif

// ==== core/scml_pkg.sv ====
// Types for the serial configuration mode loader
package scml_pkg;
   typedef enum logic [1:0] {
      SCML_MODE_MASTER,
      SCML_MODE_SLAVE,
      SCML_MODE_SCAN,
      SCML_MODE_PARALLEL
   } scml_mode_t;
   typedef enum logic [2:0] {
      SCML_ST_CLEAR,
      SCML_ST_WAIT,
      SCML_ST_LOAD,
      SCML_ST_PASS,
      SCML_ST_IDLE
   } scml_state_t;
endpackage

// ==== core/scml_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module scml_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             clr,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp_r;
   logic [AW:0]      rp_r;
   logic             push;
   logic             pop;

   assign in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);
   assign out_valid = wp_r != rp_r;
   assign out_data  = mem[rp_r[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
      end else if (clr) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end
endmodule

// ==== sim/scml_loader_properties.sv ====
// Port checker for the serial configuration loader
`timescale 1ns/1ps
module scml_chk (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic PROGRAM_N,
   input wire logic MODE_SELECT_BIT2,
   input wire logic MODE_SELECT_BIT1,
   input wire logic MODE_SELECT_BIT0,
   input wire logic MODE_PULLUP_EN,
   input wire logic CONFIG_CLOCK_I,
   input wire logic CONFIG_CLOCK_OE,
   input wire logic DOUT,
   input wire logic INIT_DONE,
   input wire logic CONFIG_DONE,
   input wire logic SCAN_MODE,
   input wire logic IO_PULLUP_EN,
   input wire logic IO_PULLDOWN_EN,
   input wire logic CFG_DATA,
   input wire logic CFG_VALID,
   input wire logic CFG_READY
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   chk_clock_drive_mode: assert property ($rose(INIT_DONE) |->
      CONFIG_CLOCK_OE == ({MODE_SELECT_BIT1, MODE_SELECT_BIT0} == 2'h0))
      else $error("clock drive wrong for mode");
   chk_mode_held: assert property (INIT_DONE && $past(INIT_DONE) && !CONFIG_DONE
      |-> $stable(CONFIG_CLOCK_OE)) else $error("mode changed during load");
   chk_scan_code: assert property ($rose(INIT_DONE) |->
      SCAN_MODE == ({MODE_SELECT_BIT1, MODE_SELECT_BIT0} == 2'h1)) else $error("scan flag wrong");
   chk_io_pullup: assert property ($rose(INIT_DONE) |-> IO_PULLUP_EN == !MODE_SELECT_BIT2)
      else $error("user pull-up wrong");
   chk_mode_pull: assert property (MODE_PULLUP_EN) else $error("mode pull-up off");
   chk_unused_pulldown: assert property ($rose(CONFIG_DONE) |-> ##[0:2] IO_PULLDOWN_EN)
      else $error("no pull-down after done");
   chk_restart_clears: assert property ($fell(PROGRAM_N) |->
      ##[1:4] !INIT_DONE && !CONFIG_DONE) else $error("restart did not clear status");
   chk_chain_edge: assert property (INIT_DONE && !CONFIG_CLOCK_OE && $changed(DOUT)
      |-> $past(CONFIG_CLOCK_I, 2)) else $error("chain output moved off clock rise");
   chk_stream_hold: assert property (CFG_VALID && !CFG_READY |=>
      CFG_VALID && $stable(CFG_DATA)) else $error("stream bit dropped while stalled");
   cover property ($rose(CONFIG_DONE) && CONFIG_CLOCK_OE);
   cover property ($rose(CONFIG_DONE) && !CONFIG_CLOCK_OE);
   cover property ($rose(INIT_DONE) && SCAN_MODE);
endmodule
bind scml_loader scml_chk u_chk (.CLK(CLK), .RSTN(RSTN), .PROGRAM_N(PROGRAM_N),
   .MODE_SELECT_BIT2(MODE_SELECT_BIT2), .MODE_SELECT_BIT1(MODE_SELECT_BIT1),
   .MODE_SELECT_BIT0(MODE_SELECT_BIT0), .MODE_PULLUP_EN(MODE_PULLUP_EN),
   .CONFIG_CLOCK_I(CONFIG_CLOCK_I), .CONFIG_CLOCK_OE(CONFIG_CLOCK_OE), .DOUT(DOUT),
   .INIT_DONE(INIT_DONE), .CONFIG_DONE(CONFIG_DONE), .SCAN_MODE(SCAN_MODE),
   .IO_PULLUP_EN(IO_PULLUP_EN), .IO_PULLDOWN_EN(IO_PULLDOWN_EN), .CFG_DATA(CFG_DATA),
   .CFG_VALID(CFG_VALID), .CFG_READY(CFG_READY));

// ==== sim/scml_src.sv ====
// Serial source model: PROM in self-clocked mode, upstream device otherwise
`timescale 1ns/1ps
module scml_src (
   input  wire logic        master,
   input  wire logic        start,
   input  wire logic [31:0] stream,
   input  wire logic [5:0]  nbits,
   input  wire logic        config_clock_in,
   input  wire logic        init_done,
   input  wire logic        done,
   input  wire logic        dout,
   output logic             config_clock_out,
   output logic             din
);
   int   idx;
   logic dq [0:31];
   initial begin
      config_clock_out = 1'h0;
      din = 1'h0;
      idx = 0;
   end
   always @(posedge start) begin
      idx = 0;
      wait (init_done && !done);
      for (idx = 0; idx < nbits; idx++) begin
         din = stream[idx];
         if (master) begin
            // PROM moves to the next bit just after each rising edge
            @(posedge config_clock_in);
         end else begin
            #32 dq[idx] = dout;
            config_clock_out = 1'h1;
            #32 config_clock_out = 1'h0;
         end
      end
      // Released line must not keep the last bit
      din = ~din;
   end
endmodule

// ==== sim/scml_loader_tb_top.sv ====
// Self-checking bench for the serial configuration loader
`timescale 1ns/1ps
`include "scml_regs.svh"
module scml_loader_tb_top;
   logic        clk, rstn, prog_n, cfg_ready, master, start, mid, fin;
   logic        config_clock_i, config_clock_o, config_clock_oe, din, dout, init_done, cfg_done, scan, pu_mode;
   logic        io_pu, io_pd, cfg_data, cfg_valid;
   logic [2:0]  msel;
   logic [3:0]  rate, flags;
   logic [5:0]  nbits;
   logic [31:0] stream;
   logic        got [0:31];
   int          ncap, miscompares, compares;
   scml_loader #(.LOAD_BITS(24), .RATE_POS(8), .CLEAR_CYC(20)) u_scml_loader (
      .CLK(clk), .RSTN(rstn), .PROGRAM_N(prog_n), .MODE_SELECT_BIT2(msel[2]),
      .MODE_SELECT_BIT1(msel[1]), .MODE_SELECT_BIT0(msel[0]), .MODE_PULLUP_EN(pu_mode),
      .CONFIG_CLOCK_I(config_clock_i), .CONFIG_CLOCK_O(config_clock_o), .CONFIG_CLOCK_OE(config_clock_oe),
      .DIN(din), .DOUT(dout), .INIT_DONE(init_done), .CONFIG_DONE(cfg_done),
      .SCAN_MODE(scan), .IO_PULLUP_EN(io_pu), .IO_PULLDOWN_EN(io_pd),
      .CLOCK_RATE_SETTING(rate), .CFG_DATA(cfg_data), .CFG_VALID(cfg_valid),
      .CFG_READY(cfg_ready));
   scml_src u_scml_src (.master(master), .start(start), .stream(stream), .nbits(nbits),
      .config_clock_in(config_clock_o), .init_done(init_done), .done(cfg_done), .dout(dout),
      .config_clock_out(config_clock_i), .din(din));
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   assign flags = {fin, mid, cfg_done, init_done};
   always @(posedge clk) begin
      mid <= u_scml_src.idx >= 16;
      fin <= u_scml_src.idx == nbits;
      if (cfg_valid === 1'h1 && cfg_ready && ncap < 32) begin
         got[ncap] = cfg_data;
         ncap = ncap + 1;
      end
   end
   task automatic finish_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_hi(input int w, input int lim);
      int n;
      for (n = 0; n < lim && flags[w] !== 1'h1; n++) begin
         @(posedge clk);
         #1;
      end
      if (flags[w] !== 1'h1) begin
         cmp("wait flag", w, 32'hffff);
         finish_test();
      end
   endtask
   task automatic wait_rise(output int n);
      logic p;
      n = 0;
      do begin
         p = config_clock_o;
         @(posedge clk);
         #1;
         n++;
      end while (!(p === 1'h0 && config_clock_o === 1'h1) && n < 300);
      if (n >= 300) begin
         cmp("clock rise", 1'h1, 1'h0);
         finish_test();
      end
   endtask
   task automatic run_mode(input logic [2:0] code, input logic [3:0] r);
      int   n;
      logic m;
      @(posedge clk);
      #1;
      m = code[1:0] == 2'h0;
      msel = code;
      master = m;
      stream = {8'hd2, 12'h9c3, r, 8'h5a};
      nbits = m ? 6'h18 : 6'h20;
      ncap = 0;
      cfg_ready = 1'h0;
      prog_n = 1'h0;
      repeat (4) @(posedge clk);
      #1 prog_n = 1'h1;
      wait_hi(0, 300);
      cmp("clock drive", m, config_clock_oe);
      cmp("io pullup", !code[2], io_pu);
      cmp("scan mode", code[1:0] == 2'h1, scan);
      repeat (4) @(posedge clk);
      #1 msel = ~code;
      if (code[1:0] inside {2'h1, 2'h2}) begin
         repeat (100) @(posedge clk);
         #1;
         cmp("no load", 2'h0, {cfg_valid, cfg_done});
         return;
      end
      start = 1'h1;
      repeat (2) @(posedge clk);
      if (m) begin
         wait_rise(n);
         wait_rise(n);
         cmp("slow period", 2 * `SCML_HALF_INIT, n);
      end
      wait_hi(2, 3000);
      cmp("mode held", m, config_clock_oe);
      cfg_ready = 1'h1;
      if (m) begin
         wait_rise(n);
         wait_rise(n);
         cmp("fast period", 2 * (r == 4'h0 ? `SCML_HALF_DFLT : `SCML_HALF_MIN), n);
      end
      wait_hi(1, 3000);
      wait_hi(3, 600);
      cmp("rate code", r, rate);
      @(posedge clk);
      #1;
      cmp("pulldown", 1'h1, io_pd);
      cmp("pullup off", 1'h0, io_pu);
      cmp("bit count", 8'h18, ncap);
      for (n = 0; n < 24; n++) cmp("load bit", stream[n], got[n]);
      for (n = 25; n < 32 && !m; n++) cmp("chain bit", stream[n-1], u_scml_src.dq[n]);
      start = 1'h0;
   endtask
   initial begin
      rstn = 1'h0;
      prog_n = 1'h1;
      msel = 3'h7;
      cfg_ready = 1'h0;
      master = 1'h0;
      start = 1'h0;
      stream = 32'h0;
      nbits = 6'h0;
      ncap = 0;
      miscompares = 0;
      compares = 0;
      repeat (4) @(posedge clk);
      #1;
      cmp("mode pullup", 1'h1, pu_mode);
      cmp("reset outputs", 5'h0, {init_done, cfg_done, cfg_valid, config_clock_oe, dout});
      rstn = 1'h1;
      run_mode(3'h7, 4'h2);
      run_mode(3'h3, 4'h0);
      run_mode(3'h0, 4'h0);
      run_mode(3'h4, 4'hf);
      run_mode(3'h5, 4'h0);
      run_mode(3'h1, 4'h0);
      run_mode(3'h6, 4'h0);
      run_mode(3'h2, 4'h0);
      finish_test();
   end
endmodule
